//--- verilog/dac_pkg.sv
// constants and types of the dual converter control block
package dac_pkg;

	typedef enum logic [2:0] {
		MODE_PDOWN = 3'b000,
		MODE_IDLE = 3'b001,
		MODE_SINGLE = 3'b010,
		MODE_CONT = 3'b011,
		MODE_IZS = 3'b100,
		MODE_IFS = 3'b101,
		MODE_SZS = 3'b110,
		MODE_SFS = 3'b111
	} dac_mode_type;

	// register byte addresses
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_MAIN_CTRL = 8'h04;
	localparam logic [7:0] ADDR_IO = 8'h08;
	localparam logic [7:0] ADDR_FLAGS = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_FILTER = 8'h18;

	// mode register fields
	localparam int MODE_OP_LSB = 0;
	localparam int MODE_BUF_BIT = 3;
	localparam int MODE_OSC_OFF_BIT = 4;
	localparam int MODE_PAIR_BIT = 5;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// main control fields
	localparam int CTRL_RANGE_LSB = 0;
	localparam int CTRL_PAIR_LSB = 3;
	localparam int CTRL_UNI_BIT = 5;
	localparam int CTRL_W16_BIT = 6;
	localparam int CTRL_EN_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// io register fields
	localparam int IO_X1_EN = 0;
	localparam int IO_X1_PIN = 1;
	localparam int IO_X2_EN = 2;
	localparam int IO_X2_PIN = 3;
	localparam int IO_BURN = 4;
	localparam int IO_P3_OUT = 5;
	localparam int IO_P4_OUT = 6;
	localparam int IO_P3_DAT = 7;
	localparam int IO_P4_DAT = 8;
	localparam int IO_P1_SW = 9;
	localparam int IO_P1_TRI = 10;
	localparam int IO_P2_SW = 11;
	localparam int IO_P2_TRI = 12;
	localparam int IO_P1_DAT = 13;
	localparam int IO_P2_DAT = 14;
	localparam int IO_WIDTH = 15;
	localparam logic [14:0] IO_RESET = 15'h0000;

	// flag register bits
	localparam int FLG_MAIN_RDY = 7;
	localparam int FLG_AUX_RDY = 6;
	localparam int FLG_CAL = 5;
	localparam int FLG_NOREF = 4;
	localparam int FLG_MAIN_ERR = 3;
	localparam int FLG_AUX_ERR = 2;

	// interrupt events
	localparam int IRQ_CAL_DONE = 0;
	localparam int IRQ_MAIN_RDY = 1;
	localparam int IRQ_AUX_RDY = 2;
	localparam int IRQ_FAULT = 3;
	localparam int IRQ_WIDTH = 4;

	localparam logic [7:0] FILTER_RESET = 8'h45;
	localparam logic [11:0] RANGE_BASE_MV = 12'h014;
	localparam int EXC_CURRENT_UA = 200;

	// calibration duration
	localparam int CLK_PERIOD_NS = 8;
	localparam int CAL_TIME_NS = 8000;
	localparam int CAL_CYCLES = CAL_TIME_NS / CLK_PERIOD_NS;

endpackage

//--- verilog/dac_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
module dac_sync #(
	parameter int WIDTH = 2
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

//--- verilog/dac_ctrl.sv
// register file and control logic of the dual converter
`timescale 1ns/100ps
module dac_ctrl
	import dac_pkg::*;
#(
	parameter int CAL_LEN = dac_pkg::CAL_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic main_done,
	input wire logic aux_done,
	input wire logic ref_missing,
	input wire logic main_fault_in,
	input wire logic aux_fault_in,
	output dac_pkg::dac_mode_type op_mode,
	output logic input_buffered,
	output logic osc_run,
	output logic input_pairing_select_bit,
	output logic main_enable,
	output logic main_word16,
	output logic main_unipolar,
	output logic [2:0] main_range,
	output logic [11:0] main_range_mv,
	output logic [1:0] main_pos_input,
	output logic [1:0] main_neg_input,
	output logic [1:0] aux_input,
	output logic [7:0] filter_word,
	output logic ready_pin,
	output logic excitation_out_pin_one,
	output logic excitation_out_pin_two,
	output logic burnout_on,
	input wire logic bidir_port_three_i,
	output logic bidir_port_three_o,
	output logic bidir_port_three_oe,
	input wire logic bidir_port_four_i,
	output logic bidir_port_four_o,
	output logic bidir_port_four_oe,
	output logic switch_port_one_o,
	output logic switch_port_one_oe,
	output logic switch_port_one_gnd,
	output logic switch_port_two_o,
	output logic switch_port_two_oe,
	output logic switch_port_two_gnd
);
	import dac_pkg::*;

	dac_mode_type mode_reg;
	logic [7:3] mode_hi_reg;
	logic [7:0] ctrl_reg;
	logic [IO_WIDTH-1:0] io_reg;
	logic [7:0] filter_reg;
	logic [IRQ_WIDTH-1:0] irq_stat_reg;
	logic [IRQ_WIDTH-1:0] irq_mask_reg;
	logic main_wait_reg;
	logic aux_wait_reg;
	logic cal_busy_reg;
	logic [15:0] cal_cnt_reg;
	logic [31:0] prdata_reg;
	logic [1:0] pin_sync;
	logic wr_acc;
	logic rd_acc;
	logic mapped;
	logic cal_start;
	logic cal_end;
	logic flags_rd;
	logic [7:0] flags;
	logic [IO_WIDTH-1:0] io_view;
	logic [IRQ_WIDTH-1:0] irq_ev;

	////////////////////////////////////////////////////////////////////
	// bus decode

	always_comb begin
		case (paddr)
			ADDR_MODE, ADDR_MAIN_CTRL, ADDR_IO, ADDR_FLAGS,
			ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_FILTER: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign wr_acc = psel & penable & pwrite & mapped;
	assign rd_acc = psel & penable & ~pwrite;
	assign flags_rd = rd_acc & (paddr == ADDR_FLAGS);
	assign prdata = prdata_reg;

	////////////////////////////////////////////////////////////////////
	// port pins and read view

	dac_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.mclk(mclk),
		.rst_b(rst_b),
		.d({bidir_port_four_i, bidir_port_three_i}),
		.q(pin_sync)
	);

	always_comb begin
		io_view = io_reg;
		// input ports show the pin level
		if (!io_reg[IO_P3_OUT]) begin
			io_view[IO_P3_DAT] = pin_sync[0];
		end
		if (!io_reg[IO_P4_OUT]) begin
			io_view[IO_P4_DAT] = pin_sync[1];
		end
	end

	always_comb begin
		flags = 8'h00;
		flags[FLG_MAIN_RDY] = main_wait_reg;
		flags[FLG_AUX_RDY] = aux_wait_reg;
		flags[FLG_CAL] = cal_busy_reg;
		flags[FLG_NOREF] = ref_missing;
		flags[FLG_MAIN_ERR] = main_fault_in;
		flags[FLG_AUX_ERR] = aux_fault_in;
	end

	// read data captured in the setup cycle
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable) begin
			case (paddr)
				ADDR_MODE: prdata_reg <= {24'h000000, mode_hi_reg, mode_reg};
				ADDR_MAIN_CTRL: prdata_reg <= {24'h000000, ctrl_reg};
				ADDR_IO: prdata_reg <= {17'h00000, io_view};
				ADDR_FLAGS: prdata_reg <= {24'h000000, flags};
				ADDR_IRQ_STAT: prdata_reg <= {28'h0000000, irq_stat_reg};
				ADDR_IRQ_MASK: prdata_reg <= {28'h0000000, irq_mask_reg};
				ADDR_FILTER: prdata_reg <= {24'h000000, filter_reg};
				default: prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode register and calibration

	assign cal_start = wr_acc && (paddr == ADDR_MODE) && pwdata[2];
	assign cal_end = cal_busy_reg && (cal_cnt_reg == 16'h0001);

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			mode_reg <= MODE_PDOWN;
			mode_hi_reg <= MODE_RESET[7:3];
		end else if (wr_acc && paddr == ADDR_MODE) begin
			mode_reg <= dac_mode_type'(pwdata[2:0]);
			mode_hi_reg <= pwdata[7:3];
		end else if (cal_end) begin
			mode_reg <= MODE_IDLE;
		end else if (mode_reg == MODE_SINGLE && main_done) begin
			mode_reg <= MODE_IDLE;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cal_busy_reg <= 1'b0;
			cal_cnt_reg <= 16'h0000;
		end else if (cal_start) begin
			cal_busy_reg <= 1'b1;
			cal_cnt_reg <= 16'(CAL_LEN);
		end else if (cal_end) begin
			cal_busy_reg <= 1'b0;
			cal_cnt_reg <= 16'h0000;
		end else if (cal_busy_reg) begin
			cal_cnt_reg <= cal_cnt_reg - 16'h0001;
		end
	end

	// ready pin high through calibration, falls at its end
	assign ready_pin = cal_busy_reg;
	assign op_mode = mode_reg;
	assign input_buffered = mode_hi_reg[MODE_BUF_BIT];
	assign osc_run = !(mode_reg == MODE_PDOWN &&
		mode_hi_reg[MODE_OSC_OFF_BIT]);
	assign input_pairing_select_bit = mode_hi_reg[MODE_PAIR_BIT];

	////////////////////////////////////////////////////////////////////
	// converter control, filter and io registers

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_acc && paddr == ADDR_MAIN_CTRL) begin
			ctrl_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			filter_reg <= FILTER_RESET;
		end else if (wr_acc && paddr == ADDR_FILTER) begin
			filter_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			io_reg <= IO_RESET;
		end else if (wr_acc && paddr == ADDR_IO) begin
			io_reg <= pwdata[IO_WIDTH-1:0];
		end
	end

	assign filter_word = filter_reg;
	assign main_enable = ctrl_reg[CTRL_EN_BIT];
	assign main_word16 = ctrl_reg[CTRL_W16_BIT];
	assign main_unipolar = ctrl_reg[CTRL_UNI_BIT];
	assign main_range = ctrl_reg[CTRL_RANGE_LSB +: 3];
	assign main_range_mv = RANGE_BASE_MV << main_range;

	// input pair table; pairing bit moves the aux input and the main negative input
	always_comb begin
		case (ctrl_reg[CTRL_PAIR_LSB +: 2])
			2'h0: begin
				main_pos_input = 2'h0;
				main_neg_input = 2'h1;
			end
			2'h1: begin
				main_pos_input = 2'h2;
				main_neg_input = 2'h3;
			end
			2'h2: begin
				main_pos_input = 2'h1;
				main_neg_input = 2'h1;
			end
			default: begin
				main_pos_input = 2'h2;
				main_neg_input = 2'h1;
			end
		endcase
		if (input_pairing_select_bit) begin
			main_neg_input = 2'h3;
			aux_input = 2'h1;
		end else begin
			aux_input = 2'h2;
		end
	end

	////////////////////////////////////////////////////////////////////
	// excitation, burnout and ports

	assign excitation_out_pin_one =
		(io_reg[IO_X1_EN] & ~io_reg[IO_X1_PIN]) |
		(io_reg[IO_X2_EN] & ~io_reg[IO_X2_PIN]);
	assign excitation_out_pin_two =
		(io_reg[IO_X1_EN] & io_reg[IO_X1_PIN]) |
		(io_reg[IO_X2_EN] & io_reg[IO_X2_PIN]);
	assign burnout_on = io_reg[IO_BURN];

	assign bidir_port_three_oe = io_reg[IO_P3_OUT];
	assign bidir_port_three_o = io_reg[IO_P3_DAT];
	assign bidir_port_four_oe = io_reg[IO_P4_OUT];
	assign bidir_port_four_o = io_reg[IO_P4_DAT];

	// switch mode closes to ground; tri-state mode drives only a one
	assign switch_port_one_gnd = io_reg[IO_P1_SW] & io_reg[IO_P1_DAT];
	assign switch_port_one_oe = !io_reg[IO_P1_SW] &&
		(!io_reg[IO_P1_TRI] || io_reg[IO_P1_DAT]);
	assign switch_port_one_o = io_reg[IO_P1_DAT];
	assign switch_port_two_gnd = io_reg[IO_P2_SW] & io_reg[IO_P2_DAT];
	assign switch_port_two_oe = !io_reg[IO_P2_SW] &&
		(!io_reg[IO_P2_TRI] || io_reg[IO_P2_DAT]);
	assign switch_port_two_o = io_reg[IO_P2_DAT];

	////////////////////////////////////////////////////////////////////
	// result flags and interrupts

	// a new result beats the clearing read
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			main_wait_reg <= 1'b0;
			aux_wait_reg <= 1'b0;
		end else begin
			main_wait_reg <= main_done | (main_wait_reg & ~flags_rd);
			aux_wait_reg <= aux_done | (aux_wait_reg & ~flags_rd);
		end
	end

	assign irq_ev = {main_fault_in | aux_fault_in, aux_done, main_done,
		cal_end};

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			irq_stat_reg <= '0;
		end else if (wr_acc && paddr == ADDR_IRQ_STAT) begin
			irq_stat_reg <= irq_ev | (irq_stat_reg & ~pwdata[IRQ_WIDTH-1:0]);
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_ev;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			irq_mask_reg <= '0;
		end else if (wr_acc && paddr == ADDR_IRQ_MASK) begin
			irq_mask_reg <= pwdata[IRQ_WIDTH-1:0];
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	a_mode_after_reset: assert property (
		$rose(rst_b) |-> mode_reg == MODE_PDOWN && mode_hi_reg == 5'h00)
		else $error("mode not zero after reset");
	a_cal_ready_high: assert property (cal_start |=> ready_pin [*3])
		else $error("ready pin not high during calibration");
	a_cal_fall_idle: assert property (
		$fell(ready_pin) |-> mode_reg == MODE_IDLE && !cal_busy_reg)
		else $error("calibration end without idle mode");
	// write, one idle cycle, then the setup of the read back
	a_ctrl_readback: assert property (
		wr_acc && paddr == ADDR_MAIN_CTRL
		##2 psel && !penable && paddr == ADDR_MAIN_CTRL
		|=> prdata[7:0] == $past(pwdata[7:0], 3))
		else $error("control register read back differs");
	a_port_in_view: assert property (
		!io_reg[IO_P3_OUT] |->
		io_view[IO_P3_DAT] == pin_sync[0] && !bidir_port_three_oe)
		else $error("input port level not shown");
	a_osc_stop: assert property (
		mode_reg == MODE_PDOWN && mode_hi_reg[MODE_OSC_OFF_BIT] |-> !osc_run)
		else $error("oscillator runs in power-down");
	a_result_set_wins: assert property (main_done |=> main_wait_reg)
		else $error("main result flag lost");
	// widened so that a wrap from seven to zero is no step up
	a_range_double: assert property (
		$changed(main_range) &&
		{1'b0, main_range} == {1'b0, $past(main_range)} + 4'h1 |->
		main_range_mv == {$past(main_range_mv[10:0]), 1'b0})
		else $error("range does not double");
	a_switch_float: assert property (
		io_reg[IO_P1_SW] |-> !switch_port_one_oe)
		else $error("switch port driven in switch mode");
	a_enable_follow: assert property (
		wr_acc && paddr == ADDR_MAIN_CTRL |=>
		main_enable == $past(pwdata[CTRL_EN_BIT]))
		else $error("enable not taken");

endmodule

//--- verif/dac_host.sv
// host controller model driving the register bus
`timescale 1ns/100ps
module dac_host (
	input wire logic mclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// one transfer; request held until pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) begin
			@(posedge mclk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

//--- verif/dual_adc_control_registers_tb_top.sv
// self-checking bench of the converter control block
`timescale 1ns/100ps
module dual_adc_control_registers_tb_top;
	import dac_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr, filter_word;
	logic [31:0] pwdata, prdata;
	logic main_done = 1'b0;
	logic aux_done = 1'b0;
	logic ref_missing = 1'b0;
	logic main_fault_in = 1'b0;
	logic aux_fault_in = 1'b0;
	logic bidir_port_three_i = 1'b0;
	logic bidir_port_four_i = 1'b0;
	dac_mode_type op_mode;
	logic input_buffered, osc_run, input_pairing_select_bit, main_enable;
	logic main_word16, main_unipolar, ready_pin, burnout_on;
	logic excitation_out_pin_one, excitation_out_pin_two;
	logic [2:0] main_range;
	logic [11:0] main_range_mv;
	logic [1:0] main_pos_input, main_neg_input, aux_input;
	logic bidir_port_three_o, bidir_port_three_oe;
	logic bidir_port_four_o, bidir_port_four_oe;
	logic switch_port_one_o, switch_port_one_oe, switch_port_one_gnd;
	logic switch_port_two_o, switch_port_two_oe, switch_port_two_gnd;
	int miscompares = 0;
	int n_compared = 0;
	localparam logic [3:0] PAIRS [4] = '{4'h1, 4'hB, 4'h5, 4'h9};
	localparam int CAL_SIM = 4;

	always #4 mclk = ~mclk;

	dac_host host (.*);
	dac_ctrl #(.CAL_LEN(CAL_SIM)) dut (.*);

	////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task step;
		@(posedge mclk);
		#1;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		host.xfer(1'b1, a, d, q, e);
		#1;
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		host.xfer(1'b0, a, 32'h0, q, e);
		#1;
		chk(q, exp);
	endtask

	task pulse(input int which);
		@(posedge mclk);
		main_done <= (which == 0);
		aux_done <= (which == 1);
		@(posedge mclk);
		main_done <= 1'b0;
		aux_done <= 1'b0;
		step();
	endtask

	////////////////////////////////////////////////////////////////////
	task t_ctrl;
		wr(ADDR_MODE, 32'h1);
		for (int r = 0; r < 8; r++) begin
			wr(ADDR_MAIN_CTRL, 32'(r));
			chk(32'(main_range_mv), 32'(20 << r));
			rdchk(ADDR_MAIN_CTRL, 32'(r));
		end
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_MAIN_CTRL, 32'(p << 3));
			chk(32'({main_pos_input, main_neg_input}), 32'(PAIRS[p]));
		end
		wr(ADDR_MAIN_CTRL, 32'hE0);
		chk(32'({main_enable, main_word16, main_unipolar}), 32'h7);
		wr(ADDR_MAIN_CTRL, 32'h00);
		chk(32'({main_enable, main_word16, main_unipolar}), 32'h0);
		chk(32'(aux_input), 32'h2);
		wr(ADDR_MODE, 32'h21);
		chk(32'({main_neg_input, aux_input}), 32'hD);
		chk(32'(input_pairing_select_bit), 32'h1);
		wr(ADDR_MODE, 32'h1);
		wr(ADDR_FILTER, 32'h0D);
		rdchk(ADDR_FILTER, 32'h0D);
		wr(ADDR_FILTER, 32'hFF);
		rdchk(ADDR_FILTER, 32'hFF);
		chk(32'(filter_word), 32'hFF);
	endtask

	task t_mode;
		int n;
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_MODE, 32'(m + 8));
			chk(32'(op_mode), 32'(m));
			chk(32'(input_buffered), 32'h1);
			rdchk(ADDR_MODE, 32'(m + 8));
		end
		wr(ADDR_MODE, 32'h10);
		chk(32'(osc_run), 32'h0);
		wr(ADDR_MODE, 32'h11);
		chk(32'(osc_run), 32'h1);
		wr(ADDR_IRQ_STAT, 32'hF);
		for (int m = 4; m < 8; m++) begin
			wr(ADDR_MODE, 32'(m));
			n = 0;
			for (int k = 0; k < 10 && ready_pin !== 1'b1; k++) begin
				step();
			end
			while (ready_pin === 1'b1 && n < 20) begin
				n++;
				step();
			end
			chk(32'(n), 32'(CAL_SIM));
			chk(32'(op_mode), 32'(MODE_IDLE));
		end
		rdchk(ADDR_IRQ_STAT, 32'h1);
	endtask

	task t_flags;
		logic [31:0] q;
		logic e;
		wr(ADDR_IRQ_STAT, 32'hF);
		wr(ADDR_IRQ_MASK, 32'h2);
		rdchk(ADDR_IRQ_MASK, 32'h2);
		chk(32'(irq), 32'h0);
		pulse(0);
		chk(32'(irq), 32'h1);
		rdchk(ADDR_FLAGS, 32'h80);
		rdchk(ADDR_FLAGS, 32'h00);
		wr(ADDR_IRQ_STAT, 32'h2);
		chk(32'(irq), 32'h0);
		pulse(1);
		chk(32'(irq), 32'h0);
		rdchk(ADDR_IRQ_STAT, 32'h4);
		@(posedge mclk);
		ref_missing <= 1'b1;
		main_fault_in <= 1'b1;
		aux_fault_in <= 1'b1;
		wr(ADDR_FLAGS, 32'hFF);
		rdchk(ADDR_FLAGS, 32'h5C);
		rdchk(ADDR_IRQ_STAT, 32'hC);
		@(posedge mclk);
		ref_missing <= 1'b0;
		main_fault_in <= 1'b0;
		aux_fault_in <= 1'b0;
		host.xfer(1'b0, 8'h1C, 32'h0, q, e);
		chk(q, 32'h0);
		chk(32'(e), 32'h1);
	endtask

	task t_io;
		wr(ADDR_IO, 32'h11);
		chk(32'({excitation_out_pin_one, excitation_out_pin_two,
			burnout_on}), 32'h5);
		wr(ADDR_IO, 32'h0E);
		chk(32'({excitation_out_pin_one, excitation_out_pin_two,
			burnout_on}), 32'h2);
		wr(ADDR_IO, 32'hE0);
		chk(32'({bidir_port_three_oe, bidir_port_three_o,
			bidir_port_four_oe, bidir_port_four_o}), 32'hE);
		rdchk(ADDR_IO, 32'hE0);
		@(posedge mclk);
		bidir_port_four_i <= 1'b1;
		wr(ADDR_IO, 32'h0);
		repeat (3) step();
		chk(32'({bidir_port_three_oe, bidir_port_four_oe}), 32'h0);
		rdchk(ADDR_IO, 32'h100);
		wr(ADDR_IO, 32'h2200);
		chk(32'({switch_port_one_oe, switch_port_one_gnd}), 32'h1);
		wr(ADDR_IO, 32'h2000);
		chk(32'({switch_port_one_oe, switch_port_one_o}), 32'h3);
		wr(ADDR_IO, 32'h5000);
		chk(32'({switch_port_two_oe, switch_port_two_o}), 32'h3);
		wr(ADDR_IO, 32'h1000);
		chk(32'({switch_port_two_oe, switch_port_two_o}), 32'h0);
		wr(ADDR_IO, 32'h4800);
		chk(32'({switch_port_two_oe, switch_port_two_gnd}), 32'h1);
	endtask

	////////////////////////////////////////////////////////////////////
	task final_report;
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		rdchk(ADDR_MODE, 32'h0);
		rdchk(ADDR_FILTER, 32'(FILTER_RESET));
		t_ctrl();
		t_mode();
		t_flags();
		t_io();
		final_report();
	end

	initial begin
		#100000;
		miscompares++;
		final_report();
	end
endmodule
